/* common/module_irq_request_pkg.sv */
// Purpose: shared constants and types for the usb event flag block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package module_irq_request_pkg;
  localparam int          MODULE_IRQ_REQUEST_AW          = 4;
  localparam int          MODULE_IRQ_REQUEST_DW          = 32;
  localparam int          MODULE_IRQ_REQUEST_NFLAG       = 8;
  localparam logic [3:0]  MODULE_IRQ_REQUEST_OFS_FLAGS   = 4'h0;
  localparam logic [3:0]  MODULE_IRQ_REQUEST_OFS_ENABLES = 4'h4;
  localparam logic [7:0]  MODULE_IRQ_REQUEST_FLAG_RST    = 8'h00;
  localparam logic [7:0]  MODULE_IRQ_REQUEST_EN_RST      = 8'h00;
  localparam logic [7:0]  MODULE_IRQ_REQUEST_ALL_ERR     = 8'hFF;
  // bit positions
  localparam int          MODULE_IRQ_REQUEST_B_STALL     = 7;
  localparam int          MODULE_IRQ_REQUEST_B_ATTACH    = 6;
  localparam int          MODULE_IRQ_REQUEST_B_RESUME    = 5;
  localparam int          MODULE_IRQ_REQUEST_B_IDLE      = 4;
  localparam int          MODULE_IRQ_REQUEST_B_TOKEN     = 3;
  localparam int          MODULE_IRQ_REQUEST_B_SOF       = 2;
  localparam int          MODULE_IRQ_REQUEST_B_ERR       = 1;
  localparam int          MODULE_IRQ_REQUEST_B_RST       = 0;
  // timing
  localparam int          MODULE_IRQ_REQUEST_CLK_HZ      = 40000000;
  localparam int          MODULE_IRQ_REQUEST_KSTATE_NS   = 2500;
  localparam int          MODULE_IRQ_REQUEST_ATTACH_NS   = 2500;
  localparam int          MODULE_IRQ_REQUEST_IDLE_MS     = 3;
  localparam int          MODULE_IRQ_REQUEST_KSTATE_CYC  = (MODULE_IRQ_REQUEST_KSTATE_NS * (MODULE_IRQ_REQUEST_CLK_HZ / 1000000)
                                               + 999) / 1000;
  localparam int          MODULE_IRQ_REQUEST_ATTACH_CYC  = (MODULE_IRQ_REQUEST_ATTACH_NS * (MODULE_IRQ_REQUEST_CLK_HZ / 1000000)
                                               + 999) / 1000;
  localparam int          MODULE_IRQ_REQUEST_IDLE_CYC    = MODULE_IRQ_REQUEST_IDLE_MS * (MODULE_IRQ_REQUEST_CLK_HZ / 1000);
  localparam int          MODULE_IRQ_REQUEST_CW          = 18;

  typedef struct packed {
    logic stall;
    logic sof;
    logic token_done;
    logic bus_reset;
    logic detach;
  } module_irq_request_evt_t;

  typedef struct packed {
    logic host_mode;
    logic host_operation_enable;
    logic bus_idle;
    logic bus_se0;
    logic kstate;
    logic attach_seen;
  } module_irq_request_line_t;
endpackage

/* rtl/module_irq_request_timer.sv */
// Purpose: counts cycles a condition holds and flags when the limit is reached
// Assumes: cond sampled synchronously to pclk
// Notes:   hit pulses once per unbroken run of cond
`timescale 1ns/100ps
module module_irq_request_timer #(
  parameter int LIMIT = 100,
  parameter int CW    = 18
) (
  // system
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // condition
  input  wire logic cond,
  output logic      hit
);
  import module_irq_request_pkg::*;
  localparam logic [CW-1:0] LIM = CW'(LIMIT);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          hit_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    hit_nxt = 1'b0;
    if (!cond) begin
      cnt_nxt = '0;
    end else if (cnt_r < LIM) begin
      cnt_nxt = cnt_r + 1'b1;
      // saturating keeps one event per run, not one per limit
      hit_nxt = (cnt_r == LIM - 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      hit   <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      hit   <= hit_nxt;
    end
  end
endmodule

/* rtl/module_irq_request_top.sv */
// Purpose: usb event flag and enable registers with one level interrupt
// Assumes: apb slave, 40 MHz pclk, events are one-cycle pulses or levels
// Notes:   flags write-one-to-clear; error summary is a live read-only bit
//
// Contract
// - flag bits 7..0 reset zero, hw sets, write one clears; bit 1 read-only
// - bit 7 set on stall handshake sent or received
// - bit 6 attach valid only with host enable, 2.5 us idle, not SE0
// - bit 5 set when K-state holds 2.5 us
// - bit 4 set after 3 ms continuous bus idle
// - bit 3 set when token processing completes
// - clearing token-done flag advances the status fifo
// - bit 2 set on sof received or host sof threshold
// - bit 1 reflects any enabled individual error
// - device mode bit 0 marks valid bus reset
// - host mode bit 0 marks peripheral detach
// - enable register bits 7..0 read-write, reset zero, per flag
// - enable bit 0 serves bus reset or detach by mode
// - error reaches interrupt only with enable bit 1 set
// - bits 31..8 read zero, ignore writes
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
module module_irq_request_top #(
  parameter int KSTATE_CYC = module_irq_request_pkg::MODULE_IRQ_REQUEST_KSTATE_CYC,
  parameter int ATTACH_CYC = module_irq_request_pkg::MODULE_IRQ_REQUEST_ATTACH_CYC,
  parameter int IDLE_CYC   = module_irq_request_pkg::MODULE_IRQ_REQUEST_IDLE_CYC
) (
  // system
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  // apb
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [3:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // usb engine events
  input  wire module_irq_request_pkg::module_irq_request_evt_t evt,
  input  wire module_irq_request_pkg::module_irq_request_line_t line,
  input  wire logic [7:0]            err_flags,
  input  wire logic [7:0]            error_enable_register,
  // outputs
  output logic                       stat_fifo_advance,
  output logic                       module_irq_request
);
  import module_irq_request_pkg::*;

  logic [7:0]  flags_r;
  logic [7:0]  flags_nxt;
  logic [7:0]  en_r;
  logic [7:0]  en_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic        adv_nxt;
  logic        irq_nxt;
  logic        err_sum_r;
  logic        err_sum_nxt;
  logic        resume_hit;
  logic        idle_hit;
  logic        attach_hit;
  logic [7:0]  set_vec;
  logic [7:0]  clr_vec;
  logic        wr_acc;
  logic        rd_acc;

  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  // duration detectors
  module_irq_request_timer #(.LIMIT(KSTATE_CYC), .CW(MODULE_IRQ_REQUEST_CW)) u_resume (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (clk_en),
    .cond    (line.kstate),
    .hit     (resume_hit)
  );

  module_irq_request_timer #(.LIMIT(IDLE_CYC), .CW(MODULE_IRQ_REQUEST_CW)) u_idle (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (clk_en),
    .cond    (line.bus_idle),
    .hit     (idle_hit)
  );

  // qualifies attach: host enabled, bus quiet and not in SE0
  module_irq_request_timer #(.LIMIT(ATTACH_CYC), .CW(MODULE_IRQ_REQUEST_CW)) u_attach (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (clk_en),
    .cond    (line.host_operation_enable & line.bus_idle & ~line.bus_se0),
    .hit     (attach_hit)
  );

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;

  always_comb begin
    set_vec = '0;
    set_vec[MODULE_IRQ_REQUEST_B_STALL]  = evt.stall;
    set_vec[MODULE_IRQ_REQUEST_B_ATTACH] = attach_hit & line.attach_seen;
    set_vec[MODULE_IRQ_REQUEST_B_RESUME] = resume_hit;
    set_vec[MODULE_IRQ_REQUEST_B_IDLE]   = idle_hit;
    set_vec[MODULE_IRQ_REQUEST_B_TOKEN]  = evt.token_done;
    set_vec[MODULE_IRQ_REQUEST_B_SOF]    = evt.sof;
    // bit 0 source follows the mode
    set_vec[MODULE_IRQ_REQUEST_B_RST]    = line.host_mode ? evt.detach : evt.bus_reset;
  end

  always_comb begin
    clr_vec = '0;
    if (wr_acc && addr_hit(paddr, MODULE_IRQ_REQUEST_OFS_FLAGS)) begin
      clr_vec = pwdata[7:0];
    end
    clr_vec[MODULE_IRQ_REQUEST_B_ERR] = 1'b0;
  end

  always_comb begin
    flags_nxt   = (flags_r & ~clr_vec) | set_vec;
    flags_nxt[MODULE_IRQ_REQUEST_B_ERR] = 1'b0;
    en_nxt      = en_r;
    if (wr_acc && addr_hit(paddr, MODULE_IRQ_REQUEST_OFS_ENABLES)) begin
      en_nxt = pwdata[7:0];
    end
    err_sum_nxt = |(err_flags & error_enable_register & MODULE_IRQ_REQUEST_ALL_ERR);
    // fifo steps only when a write-one clear hits a token flag that is set, even if a new token event sets it again
    adv_nxt     = clr_vec[MODULE_IRQ_REQUEST_B_TOKEN] & flags_r[MODULE_IRQ_REQUEST_B_TOKEN];
    irq_nxt     = |({flags_nxt[7:2], err_sum_nxt, flags_nxt[0]} & en_nxt);
  end

  always_comb begin
    prdata_nxt  = '0;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (psel && !penable) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !(addr_hit(paddr, MODULE_IRQ_REQUEST_OFS_FLAGS) || addr_hit(paddr, MODULE_IRQ_REQUEST_OFS_ENABLES));
      if (!pwrite && addr_hit(paddr, MODULE_IRQ_REQUEST_OFS_FLAGS)) begin
        prdata_nxt = {24'h000000, flags_r[7:2], err_sum_r, flags_r[0]};
      end else if (!pwrite && addr_hit(paddr, MODULE_IRQ_REQUEST_OFS_ENABLES)) begin
        prdata_nxt = {24'h000000, en_r};
      end
    end else if (psel && penable) begin
      // hold the answer through the access cycle
      prdata_nxt  = rd_acc ? prdata : '0;
      pslverr_nxt = pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r            <= MODULE_IRQ_REQUEST_FLAG_RST;
      en_r               <= MODULE_IRQ_REQUEST_EN_RST;
      err_sum_r          <= 1'b0;
      prdata             <= '0;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
      stat_fifo_advance  <= 1'b0;
      module_irq_request <= 1'b0;
    end else if (clk_en) begin
      flags_r            <= flags_nxt;
      en_r               <= en_nxt;
      err_sum_r          <= err_sum_nxt;
      prdata             <= prdata_nxt;
      pready             <= pready_nxt;
      pslverr            <= pslverr_nxt;
      stat_fifo_advance  <= adv_nxt;
      module_irq_request <= irq_nxt;
    end
  end
endmodule

/* bench/module_irq_request_chk.sv */
// Purpose: port checks of the usb event flag block
// Assumes: zero wait apb, one clock domain
// Notes:   flags are not visible here, only their side effects
`timescale 1ns/100ps
module module_irq_request_chk (
  // system
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [3:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // outputs
  input wire logic        stat_fifo_advance,
  input wire logic        module_irq_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_acc; s_setup ##1 psel && penable; endsequence
  wire clr_tok = psel && penable && pwrite && paddr == 4'h0 && pwdata[3];
  AST_RDY: assert property (s_setup |=> pready && penable) else $error("ready missing");
  AST_ONE: assert property (s_acc |=> !pready) else $error("ready too long");
  AST_MAP: assert property (psel && !penable && paddr != 4'h0 && paddr != 4'h4 |=> pslverr)
    else $error("unmapped not refused");
  AST_OK: assert property (psel && !penable && (paddr == 4'h0 || paddr == 4'h4) |=> !pslverr)
    else $error("mapped refused");
  AST_UNM: assert property (pslverr |-> prdata == 32'h0) else $error("refused read data");
  AST_HI: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  AST_FIFO: assert property (stat_fifo_advance |-> $past(clr_tok)) else $error("stray advance");
  AST_PLS: assert property (stat_fifo_advance |=> !stat_fifo_advance) else $error("long advance");
  AST_RST: assert property ($rose(presetn) |-> !module_irq_request && !pready)
    else $error("outputs after reset");
endmodule

/* bench/module_irq_request_bus_model.sv */
// Purpose: stands in for the cable side: event pulses and line levels
// Assumes: each event lasts one pclk cycle
// Notes:   line levels follow the bench request directly
`timescale 1ns/100ps
module module_irq_request_bus_model
  import module_irq_request_pkg::*;
(
  // system
  input  wire logic                   pclk,
  // request
  input  wire logic [2:0]             kind,
  input  wire logic                   fire,
  input  wire module_irq_request_pkg::module_irq_request_line_t lv,
  // cable side
  output module_irq_request_pkg::module_irq_request_evt_t       evt,
  output module_irq_request_pkg::module_irq_request_line_t      line
);
  module_irq_request_evt_t evt_r = '0;
  // kind 0 stall, 1 sof, 2 token done, 3 bus reset, 4 detach
  always @(posedge pclk) begin
    evt_r <= fire ? module_irq_request_evt_t'(5'h10 >> kind) : '0;
  end
  assign evt  = evt_r;
  assign line = lv;
endmodule

/* bench/module_irq_request_top_tb.sv */
// Purpose: self-checking bench of the usb event flag block
// Assumes: timer limits shortened to 4, 4 and 20 cycles
// Notes:   clk_en held high, so the freeze path is not exercised
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module module_irq_request_top_tb;
  import module_irq_request_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [3:0]  paddr = 4'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, fifo_adv, irq;
  logic [2:0]  kind = 3'h0;
  logic [7:0]  err = 8'h00, eer = 8'h00;
  module_irq_request_line_t lv = '0, line;
  module_irq_request_evt_t  evt;
  int          fails = 0, total_checks = 0, cyc = 0;
  // line, event kind (FF none), hold cycles, expected flags
  logic [31:0] rows [13] = '{32'h00000280, 32'h00010204, 32'h00020208, 32'h00030201,
    32'h20040201, 32'h20030200, 32'h00040200, 32'h02FF0200, 32'h02FF0820, 32'h08FF1E10,
    32'h39FF0840, 32'h3DFF0800, 32'h29FF0800};
  module_irq_request_top #(.KSTATE_CYC(4), .ATTACH_CYC(4), .IDLE_CYC(20)) DUT (.pclk, .presetn,
    .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .evt, .line, .err_flags(err), .error_enable_register(eer),
    .stat_fifo_advance(fifo_adv), .module_irq_request(irq));
  module_irq_request_bus_model u_bus (.pclk, .kind, .fire, .lv, .evt, .line);
  initial forever #12.5 pclk = ~pclk;
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up;
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 4'h0, 0); `CHK("flags reset", 32'h0, q)
    apb(0, 4'h4, 0); `CHK("enables reset", 32'h0, q)
    for (int i = 0; i < 13; i++) begin
      @(posedge pclk);
      lv <= rows[i][29:24];
      fire <= rows[i][23:16] != 8'hFF;
      kind <= rows[i][18:16];
      @(posedge pclk);
      fire <= 1'b0;
      repeat (rows[i][15:8]) @(posedge pclk);
      lv <= '0;
      repeat (2) @(posedge pclk);
      apb(0, 4'h0, 0); `CHK("flag", {24'h0, rows[i][7:0]}, q)
      apb(1, 4'h0, 32'hFFFF_FFFF);
      apb(0, 4'h0, 0); `CHK("cleared", 32'h0, q)
      $display("row %0d done", i);
    end
    // resume enable stays clear outside suspend
    apb(1, 4'h4, 32'hFFFF_FFDF);
    apb(0, 4'h4, 0); `CHK("enables rw", 32'hDF, q)
    @(posedge pclk);
    fire <= 1'b1;
    kind <= 3'h0;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (3) @(posedge pclk); `CHK("irq on", 1'b1, irq)
    apb(1, 4'h4, 32'h5F);
    repeat (2) @(posedge pclk); `CHK("irq masked", 1'b0, irq)
    apb(1, 4'h0, 32'hFF);
    err <= 8'h01;
    apb(0, 4'h0, 0); `CHK("error unmasked off", 32'h0, q)
    eer <= 8'h01;
    repeat (2) @(posedge pclk);
    apb(0, 4'h0, 0); `CHK("error summary", 32'h2, q)
    `CHK("irq error", 1'b1, irq)
    apb(1, 4'h0, 32'hFF);
    apb(0, 4'h0, 0); `CHK("summary read only", 32'h2, q)
    apb(1, 4'h4, 32'h5D);
    repeat (2) @(posedge pclk); `CHK("irq error masked", 1'b0, irq)
    err <= 8'h00;
    apb(1, 4'h8, 32'hFF);
    apb(0, 4'h8, 0); `CHK("unmapped", 32'h0, q)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 4'h4, 0); `CHK("enables second reset", 32'h0, q)
    $display("hand tests done");
    wrap_up;
  end
endmodule
bind module_irq_request_top module_irq_request_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .stat_fifo_advance, .module_irq_request);
